// ==== mhc_misc_cfg.sv ====
// mhc_misc_cfg: miscellaneous host configuration register with its effects
// on link access termination, pin routing, clock gating and clock run.
// assumes configuration cycles arrive as single-cycle strobes on i_clk_sys.
`timescale 1ns/1ps
module mhc_misc_cfg (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_reset,
    // configuration access
    input  wire logic                          i_cfg_wr,
    input  wire logic                          i_cfg_rd,
    input  wire logic [mhc_pkg::CFG_AW-1:0]    i_cfg_addr,
    input  wire logic [mhc_pkg::CFG_BEW-1:0]   i_cfg_be,
    input  wire logic [mhc_pkg::CFG_DW-1:0]    i_cfg_wdata,
    output logic                               o_cfg_ack,
    output logic [mhc_pkg::CFG_DW-1:0]         o_cfg_rdata,
    output logic                               o_cold_wake_cap,
    // host access to link-domain registers
    input  wire logic                          i_link_req,
    input  wire logic                          i_link_clk_running,
    input  wire logic [mhc_pkg::LINK_DW-1:0]   i_link_rdata,
    output logic                               o_link_done,
    output logic                               o_link_abort,
    output logic [mhc_pkg::LINK_DW-1:0]        o_link_rdata,
    // clock control
    output logic                               o_link_clock_gate_bypass,
    output logic                               o_host_clock_gate_bypass,
    input  wire logic                          i_clock_stop_req,
    output logic                               o_clock_run_request,
    // pins
    input  wire logic                          i_gp3_out,
    input  wire logic                          i_gp3_oe_n,
    input  wire logic                          i_gp2_out,
    input  wire logic                          i_gp2_oe_n,
    input  wire logic                          i_scl_out,
    input  wire logic                          i_scl_oe_n,
    input  wire logic                          i_sda_out,
    input  wire logic                          i_sda_oe_n,
    input  wire logic                          i_gp3_pin_in,
    input  wire logic                          i_gp2_pin_in,
    input  wire logic                          i_scl_pin_in,
    input  wire logic                          i_sda_pin_in,
    output logic                               o_gp3_pin_out,
    output logic                               o_gp3_pin_oe_n,
    output logic                               o_gp2_pin_out,
    output logic                               o_gp2_pin_oe_n,
    output logic                               o_scl_pin_out,
    output logic                               o_scl_pin_oe_n,
    output logic                               o_sda_pin_out,
    output logic                               o_sda_pin_oe_n,
    output logic                               o_gp3_in,
    output logic                               o_gp2_in
);
    function automatic logic [7:0] lane_mask(input logic [3:0] be, input int lane);
        lane_mask = be[lane] ? 8'hff : 8'h00;
    endfunction : lane_mask

    // register bank
    logic [31:0] misc_q;
    logic [31:0] misc_d;
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        hit;
    logic [31:0] be_mask;

    assign hit = (i_cfg_addr == mhc_pkg::MISC_CFG_OFFSET);

    always_comb begin
        be_mask = {lane_mask(i_cfg_be, 3), lane_mask(i_cfg_be, 2),
                   lane_mask(i_cfg_be, 1), lane_mask(i_cfg_be, 0)};
        be_mask = be_mask & mhc_pkg::MISC_CFG_WMASK;
        misc_d  = misc_q;
        if (i_cfg_wr && hit) begin
            misc_d = (misc_q & ~be_mask) | (i_cfg_wdata & be_mask);
        end
        ack_d   = i_cfg_wr | i_cfg_rd;
        rdata_d = 32'h0000_0000;
        if (i_cfg_rd && hit) begin
            // upper half and bits fourteen to five never hold ones
            rdata_d = misc_q & mhc_pkg::MISC_CFG_WMASK;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            misc_q  <= mhc_pkg::MISC_CFG_RESET;
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            misc_q  <= misc_d;
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_cfg_ack   = ack_q;
    assign o_cfg_rdata = rdata_q;

    // effects of the control bits
    logic       no_abort;
    logic [3:0] ctl_d;
    logic [3:0] ctl_q;

    assign no_abort = misc_q[mhc_pkg::NO_ABORT_BIT];

    always_comb begin
        ctl_d = {misc_q[mhc_pkg::COLD_WAKE_BIT],
                 misc_q[mhc_pkg::LINK_GATE_BYP_BIT],
                 misc_q[mhc_pkg::HOST_GATE_BYP_BIT],
                 // hold the clock only while someone asks to stop it
                 misc_q[mhc_pkg::KEEP_CLOCK_BIT] & i_clock_stop_req};
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ctl_q <= 4'h0;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign o_cold_wake_cap          = ctl_q[3];
    assign o_link_clock_gate_bypass = ctl_q[2];
    assign o_host_clock_gate_bypass = ctl_q[1];
    assign o_clock_run_request      = ctl_q[0];

    // termination of host accesses that reach link-domain registers
    logic       done_d;
    logic       done_q;
    logic       abort_d;
    logic       abort_q;
    logic [7:0] ldata_d;
    logic [7:0] ldata_q;

    always_comb begin
        done_d  = 1'b0;
        abort_d = 1'b0;
        ldata_d = 8'h00;
        if (i_link_req) begin
            if (i_link_clk_running) begin
                done_d  = 1'b1;
                ldata_d = i_link_rdata;
            end else if (no_abort) begin
                // avoids a fatal system error on hosts that trap aborts
                done_d  = 1'b1;
                ldata_d = mhc_pkg::LINK_STOPPED_DATA;
            end else begin
                abort_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            done_q  <= 1'b0;
            abort_q <= 1'b0;
            ldata_q <= 8'h00;
        end else begin
            done_q  <= done_d;
            abort_q <= abort_d;
            ldata_q <= ldata_d;
        end
    end

    assign o_link_done  = done_q;
    assign o_link_abort = abort_q;
    assign o_link_rdata = ldata_q;

    // pin routing
    mhc_route_if route_bus ();

    assign route_bus.route_en = misc_q[mhc_pkg::PIN_ROUTE_BIT];

    mhc_pin_route u_pin_route (
        .i_clk_sys      (i_clk_sys),
        .i_reset        (i_reset),
        .ctl            (route_bus),
        .i_gp3_out      (i_gp3_out),
        .i_gp3_oe_n     (i_gp3_oe_n),
        .i_gp2_out      (i_gp2_out),
        .i_gp2_oe_n     (i_gp2_oe_n),
        .i_scl_out      (i_scl_out),
        .i_scl_oe_n     (i_scl_oe_n),
        .i_sda_out      (i_sda_out),
        .i_sda_oe_n     (i_sda_oe_n),
        .i_gp3_pin_in   (i_gp3_pin_in),
        .i_gp2_pin_in   (i_gp2_pin_in),
        .i_scl_pin_in   (i_scl_pin_in),
        .i_sda_pin_in   (i_sda_pin_in),
        .o_gp3_pin_out  (o_gp3_pin_out),
        .o_gp3_pin_oe_n (o_gp3_pin_oe_n),
        .o_gp2_pin_out  (o_gp2_pin_out),
        .o_gp2_pin_oe_n (o_gp2_pin_oe_n),
        .o_scl_pin_out  (o_scl_pin_out),
        .o_scl_pin_oe_n (o_scl_pin_oe_n),
        .o_sda_pin_out  (o_sda_pin_out),
        .o_sda_pin_oe_n (o_sda_pin_oe_n),
        .o_gp3_in       (o_gp3_in),
        .o_gp2_in       (o_gp2_in)
    );

endmodule : mhc_misc_cfg

// ==== mhc_pkg.sv ====
// mhc_pkg: offsets, field positions, reset values and write mask for the
// miscellaneous host configuration register bank.
// assumes a 32-bit configuration data path with byte-granular enables.
package mhc_pkg;

    localparam int          CFG_AW             = 8;
    localparam int          CFG_DW             = 32;
    localparam int          CFG_BEW            = 4;
    localparam int          LINK_DW            = 8;

    localparam logic [7:0]  MISC_CFG_OFFSET    = 8'hf0;
    localparam logic [7:0]  PM_CAP_OFFSET      = 8'h46;
    localparam logic [31:0] MISC_CFG_RESET     = 32'h0000_0000;

    localparam int          COLD_WAKE_BIT      = 15;
    localparam int          NO_ABORT_BIT       = 4;
    localparam int          PIN_ROUTE_BIT      = 3;
    localparam int          LINK_GATE_BYP_BIT  = 2;
    localparam int          HOST_GATE_BYP_BIT  = 1;
    localparam int          KEEP_CLOCK_BIT     = 0;
    localparam int          PM_CAP_COLD_BIT    = 15;

    // lanes that carry writable bits
    localparam int          LOW_LANE           = 0;
    localparam int          HIGH_LANE          = 1;

    // writable positions; everything else reads zero
    localparam logic [31:0] MISC_CFG_WMASK     = 32'h0000_801f;

    localparam logic [7:0]  LINK_STOPPED_DATA  = 8'hff;

endpackage : mhc_pkg

// ==== mhc_route_if.sv ====
// mhc_route_if: carries the pin-rerouting control from the register bank
// to the pin router.
// assumes both ends share i_clk_sys.
`timescale 1ns/1ps
interface mhc_route_if;
    logic route_en;

    modport ctrl  (output route_en);
    modport route (input  route_en);
endinterface : mhc_route_if

// ==== mhc_pin_route.sv ====
// mhc_pin_route: steers the general pins three and two onto the serial
// eeprom clock and data terminals.
// assumes all pin inputs are synchronous to i_clk_sys; oe_n low means driving.
`timescale 1ns/1ps
module mhc_pin_route (
    input  wire logic   i_clk_sys,
    input  wire logic   i_reset,
    mhc_route_if.route  ctl,
    input  wire logic   i_gp3_out,
    input  wire logic   i_gp3_oe_n,
    input  wire logic   i_gp2_out,
    input  wire logic   i_gp2_oe_n,
    input  wire logic   i_scl_out,
    input  wire logic   i_scl_oe_n,
    input  wire logic   i_sda_out,
    input  wire logic   i_sda_oe_n,
    input  wire logic   i_gp3_pin_in,
    input  wire logic   i_gp2_pin_in,
    input  wire logic   i_scl_pin_in,
    input  wire logic   i_sda_pin_in,
    output logic        o_gp3_pin_out,
    output logic        o_gp3_pin_oe_n,
    output logic        o_gp2_pin_out,
    output logic        o_gp2_pin_oe_n,
    output logic        o_scl_pin_out,
    output logic        o_scl_pin_oe_n,
    output logic        o_sda_pin_out,
    output logic        o_sda_pin_oe_n,
    output logic        o_gp3_in,
    output logic        o_gp2_in
);
    logic [9:0] pins_d;
    logic [9:0] pins_q;

    always_comb begin
        if (ctl.route_en) begin
            // general pin functions appear on the eeprom terminals
            pins_d = {1'b0, 1'b1, 1'b0, 1'b1,
                      i_gp3_out, i_gp3_oe_n, i_gp2_out, i_gp2_oe_n,
                      i_scl_pin_in, i_sda_pin_in};
        end else begin
            pins_d = {i_gp3_out, i_gp3_oe_n, i_gp2_out, i_gp2_oe_n,
                      i_scl_out, i_scl_oe_n, i_sda_out, i_sda_oe_n,
                      i_gp3_pin_in, i_gp2_pin_in};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pins_q <= 10'h3ff;
        end else begin
            pins_q <= pins_d;
        end
    end

    assign o_gp3_pin_out  = pins_q[9];
    assign o_gp3_pin_oe_n = pins_q[8];
    assign o_gp2_pin_out  = pins_q[7];
    assign o_gp2_pin_oe_n = pins_q[6];
    assign o_scl_pin_out  = pins_q[5];
    assign o_scl_pin_oe_n = pins_q[4];
    assign o_sda_pin_out  = pins_q[3];
    assign o_sda_pin_oe_n = pins_q[2];
    assign o_gp3_in       = pins_q[1];
    assign o_gp2_in       = pins_q[0];

endmodule : mhc_pin_route

// ==== mhc_misc_cfg_checker.sv ====
// mhc_misc_cfg_checker: port assertions for the miscellaneous host configuration register.
// assumes it is bound into mhc_misc_cfg and sees that module's ports only.
`timescale 1ns/1ps
module mhc_misc_cfg_checker (
    input wire logic        i_clk_sys,
    input wire logic        i_reset,
    input wire logic        i_cfg_wr,
    input wire logic [7:0]  i_cfg_addr,
    input wire logic [3:0]  i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic        o_cold_wake_cap,
    input wire logic        i_link_req,
    input wire logic        i_link_clk_running,
    input wire logic        o_link_done,
    input wire logic        o_link_abort,
    input wire logic [7:0]  o_link_rdata,
    input wire logic        i_clock_stop_req,
    input wire logic        o_clock_run_request,
    input wire logic        o_gp3_pin_oe_n,
    input wire logic        o_gp2_pin_oe_n
);
    // shadow of the writable bits, so link and pin checks know the mode
    logic [15:0] sh_q;
    logic [15:0] sh_d;
    always_comb begin
        sh_d = sh_q;
        if (i_cfg_wr && i_cfg_addr == 8'hf0 && i_cfg_be[0]) sh_d[4:0] = i_cfg_wdata[4:0];
        if (i_cfg_wr && i_cfg_addr == 8'hf0 && i_cfg_be[1]) sh_d[15] = i_cfg_wdata[15];
    end
    always_ff @(posedge i_clk_sys) begin
        sh_q <= i_reset ? 16'h0 : sh_d;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    a_upper_reads_zero: assert property (o_cfg_rdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    a_resv_reads_zero: assert property (o_cfg_rdata[14:5] == 10'h0)
        else $error("reserved read bits not zero");
    a_cold_wake_mirror: assert property (1'b1 |=> o_cold_wake_cap == $past(sh_q[15]))
        else $error("cold wake copy wrong");
    a_stop_gives_abort: assert property (
        i_link_req && !i_link_clk_running && !sh_q[4] |=> o_link_abort && !o_link_done)
        else $error("stopped access not aborted");
    a_stop_no_abort: assert property (
        i_link_req && !i_link_clk_running && sh_q[4] |=> o_link_done && !o_link_abort)
        else $error("stopped access not completed");
    a_stop_all_ones: assert property (
        o_link_done && !$past(i_link_clk_running) |-> o_link_rdata == 8'hff)
        else $error("stopped access data not all ones");
    a_route_pins_hiz: assert property (sh_q[3] |=> o_gp3_pin_oe_n && o_gp2_pin_oe_n)
        else $error("rerouted pins still driven");
    a_clock_run_hold: assert property (
        1'b1 |=> o_clock_run_request == $past(sh_q[0] && i_clock_stop_req))
        else $error("clock run request wrong");
endmodule : mhc_misc_cfg_checker

bind mhc_misc_cfg mhc_misc_cfg_checker u_mhc_misc_cfg_checker (
    .i_clk_sys, .i_reset, .i_cfg_wr, .i_cfg_addr, .i_cfg_be, .i_cfg_wdata, .o_cfg_rdata,
    .o_cold_wake_cap, .i_link_req, .i_link_clk_running, .o_link_done, .o_link_abort,
    .o_link_rdata, .i_clock_stop_req, .o_clock_run_request, .o_gp3_pin_oe_n,
    .o_gp2_pin_oe_n);

// ==== mhc_host_model.sv ====
// mhc_host_model: host bus master issuing configuration cycles.
// assumes the bench calls its task; drives only on falling edges.
`timescale 1ns/1ps
module mhc_host_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_ack,
    input  wire logic [31:0] i_rdata,
    output logic             o_wr,
    output logic             o_rd,
    output logic [7:0]       o_addr,
    output logic [3:0]       o_be,
    output logic [31:0]      o_wdata
);
    initial {o_wr, o_rd, o_addr, o_be, o_wdata} = '0;
    // strobe lasts one cycle; released address, enables and data go inverted, not stale
    task automatic cycle(input logic w, input logic [7:0] a, input logic [3:0] b,
                         input logic [31:0] d, output logic k, output logic [31:0] q);
        @(negedge i_clk_sys);
        {o_wr, o_rd, o_addr, o_be, o_wdata} = {w, !w, a, b, d};
        @(negedge i_clk_sys);
        {o_wr, o_rd, o_addr, o_be, o_wdata} = {2'b00, ~a, ~b, ~d};
        k = i_ack;
        q = i_rdata;
    endtask : cycle
endmodule : mhc_host_model

// ==== tb_top.sv ====
// tb_top: random and corner checks of mhc_misc_cfg at its ports.
// assumes mhc_pkg, mhc_host_model and the checker are compiled first.
`timescale 1ns/1ps
module tb_top;
    logic        i_clk_sys = 0, i_reset = 1, i_cfg_wr, i_cfg_rd, o_cfg_ack, o_cold_wake_cap;
    logic        i_link_req, i_link_clk_running, o_link_done, o_link_abort, i_clock_stop_req;
    logic        o_link_clock_gate_bypass, o_host_clock_gate_bypass, o_clock_run_request;
    logic        i_gp3_out, i_gp3_oe_n, i_gp2_out, i_gp2_oe_n, i_scl_out, i_scl_oe_n;
    logic        i_sda_out, i_sda_oe_n, i_gp3_pin_in, i_gp2_pin_in, i_scl_pin_in, i_sda_pin_in;
    logic        o_gp3_pin_out, o_gp3_pin_oe_n, o_gp2_pin_out, o_gp2_pin_oe_n, o_scl_pin_out;
    logic        o_scl_pin_oe_n, o_sda_pin_out, o_sda_pin_oe_n, o_gp3_in, o_gp2_in;
    logic [7:0]  i_cfg_addr, i_link_rdata, o_link_rdata;
    logic [3:0]  i_cfg_be;
    logic [11:0] p = 12'h0;
    logic [31:0] i_cfg_wdata, o_cfg_rdata, exp_q, lfsr = 32'h3b5a;
    int          failures = 0, compares = 0;

    assign {i_gp3_out, i_gp3_oe_n, i_gp2_out, i_gp2_oe_n, i_scl_out, i_scl_oe_n, i_sda_out,
            i_sda_oe_n, i_gp3_pin_in, i_gp2_pin_in, i_scl_pin_in, i_sda_pin_in} = p;
    mhc_misc_cfg u_mhc_misc_cfg (.*);
    mhc_host_model u_mhc_host_model (.i_clk_sys, .i_ack(o_cfg_ack), .i_rdata(o_cfg_rdata),
        .o_wr(i_cfg_wr), .o_rd(i_cfg_rd), .o_addr(i_cfg_addr), .o_be(i_cfg_be),
        .o_wdata(i_cfg_wdata));

    always #25 i_clk_sys = ~i_clk_sys;

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    // pin outputs expected one cycle after the pin inputs and the routing bit
    function automatic logic [9:0] exp_pins(input logic route, input logic [11:0] v);
        return route ? {4'b0101, v[11:8], v[1:0]} : {v[11:4], v[3:2]};
    endfunction : exp_pins

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    // writes elsewhere must leave the register alone; reads elsewhere return zero
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d);
        logic        k;
        logic [31:0] q, m;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & mhc_pkg::MISC_CFG_WMASK;
        u_mhc_host_model.cycle(w, a, b, d, k, q);
        chk(k, 1'b1);
        if (w && a == mhc_pkg::MISC_CFG_OFFSET)
            exp_q = (exp_q & ~m) | (d & m);
        if (!w)
            chk(q, a == mhc_pkg::MISC_CFG_OFFSET ? exp_q : 32'h0);
    endtask : acc

    task automatic probe;
        lfsr = nxt(lfsr);
        p = lfsr[11:0];
        {i_link_clk_running, i_clock_stop_req, i_link_rdata} = lfsr[21:12];
        i_link_req = 1;
        @(negedge i_clk_sys);
        i_link_req = 0;
        chk({o_link_done, o_link_abort}, i_link_clk_running || exp_q[4] ? 2'b10 : 2'b01);
        chk(o_link_rdata, i_link_clk_running ? i_link_rdata : exp_q[4] ? 8'hff : 8'h0);
        chk({o_gp3_pin_out, o_gp3_pin_oe_n, o_gp2_pin_out, o_gp2_pin_oe_n, o_scl_pin_out,
             o_scl_pin_oe_n, o_sda_pin_out, o_sda_pin_oe_n, o_gp3_in, o_gp2_in},
            exp_pins(exp_q[3], p));
        chk({o_cold_wake_cap, o_link_clock_gate_bypass, o_host_clock_gate_bypass},
            {exp_q[15], exp_q[2:1]});
        chk(o_clock_run_request, exp_q[0] & i_clock_stop_req);
    endtask : probe

    initial begin
        {i_link_req, i_link_clk_running, i_clock_stop_req, i_link_rdata} = '0;
        exp_q = mhc_pkg::MISC_CFG_RESET;
        repeat (20) @(negedge i_clk_sys);
        i_reset = 0;
        acc(0, mhc_pkg::MISC_CFG_OFFSET, 4'hf, 32'h0);
        acc(1, mhc_pkg::MISC_CFG_OFFSET, 4'hf, 32'hffff_ffff);
        acc(0, mhc_pkg::MISC_CFG_OFFSET, 4'hf, 32'h0);
        probe;
        for (int i = 0; i < 40; i++) begin
            lfsr = nxt(lfsr);
            acc(1, lfsr[0] ? mhc_pkg::MISC_CFG_OFFSET : lfsr[15:8], lfsr[7:4], nxt(lfsr));
            acc(0, lfsr[1] ? mhc_pkg::MISC_CFG_OFFSET : lfsr[23:16], 4'hf, 32'h0);
            probe;
        end
        // a reset in mid-run must drop every control back to its cleared state
        i_reset = 1;
        exp_q = mhc_pkg::MISC_CFG_RESET;
        repeat (3) @(negedge i_clk_sys);
        i_reset = 0;
        probe;
        acc(1, mhc_pkg::MISC_CFG_OFFSET, 4'h1, 32'h10);
        probe;
        test_done;
    end

    // about eight times the expected run length of some 240 cycles
    initial begin
        #(2000 * 50);
        failures++;
        test_done;
    end
endmodule : tb_top
